// [ihiu_map.vh]
`ifndef IHIU_MAP_VH
`define IHIU_MAP_VH

// Host port direct addresses
`define IHIU_ADDR_CAUSE    3'h0
`define IHIU_ADDR_DSTAT1   3'h2
`define IHIU_ADDR_DERR     3'h3
`define IHIU_ADDR_DSTAT2   3'h7

// Cause register layout
`define IHIU_CB_DTX        0
`define IHIU_CB_DRX        1
`define IHIU_CB_DSTAT1     2
`define IHIU_CB_DERR       3
`define IHIU_CB_BCHAN      4
`define IHIU_CB_LINE       5
`define IHIU_CB_DSTAT2     6
`define IHIU_CB_PORT       7
`define IHIU_CAUSE_RST     8'h00

// Enable and status bit positions
`define IHIU_M1_TX         0
`define IHIU_M1_RX         1
`define IHIU_M1_EOF        3
`define IHIU_M3_ADDR       0
`define IHIU_M3_FLAGTX     1
`define IHIU_M3_LOST       6
`define IHIU_S1_ADDR       0
`define IHIU_S1_EOF        1
`define IHIU_S1_FLAGTX     6
`define IHIU_S2_LOST       2
`define IHIU_S2_SECOND     7
`define IHIU_EF_SECOND     1
`define IHIU_MUX4_BCHAN    3
`define IHIU_PIE_GLOBAL    7

// Status 2 group source bit, mask 3 enable bit
`define IHIU_S2_LASTRX     0
`define IHIU_S2_BYTERX     1
`define IHIU_S2_LASTTX     3
`define IHIU_S2_SPACETX    4
`define IHIU_M3_LASTRX     2
`define IHIU_M3_BYTERX     3
`define IHIU_M3_LASTTX     4
`define IHIU_M3_SPACETX    5

// Group widths and first bit positions
`define IHIU_ERR_N         8
`define IHIU_LINE_N        4
`define IHIU_S2_N          4
`define IHIU_MF_N          3
`define IHIU_MFS_LO        5
`define IHIU_MFC_LO        1
`define IHIU_PS_N          7

// Line status bit, line mode 2 enable bit
`define IHIU_LS_F3         3
`define IHIU_LS_F7         4
`define IHIU_LS_F8         5
`define IHIU_LS_HOOK       7
`define IHIU_LM_F3         3
`define IHIU_LM_F7         6
`define IHIU_LM_F8         4
`define IHIU_LM_HOOK       5

// Frame timing
`define IHIU_CLK_NS        100
`define IHIU_FRAME_NS      125000
`define IHIU_FRAME_CYC     (`IHIU_FRAME_NS / `IHIU_CLK_NS)
`define IHIU_FCNT_W        11
`define IHIU_FCNT_ZERO     11'h000
`define IHIU_FCNT_ONE      11'h001
`define IHIU_FCNT_LAST     11'h4e1

`endif

// [ihiu_frame_timer.v]
`timescale 1ns/1ps
`include "ihiu_map.vh"

module ihiu_frame_timer (
  // System
  input  wire clk_i,
  input  wire rst_i,
  // Frame boundary
  output wire tick_o
);

  localparam [`IHIU_FCNT_W-1:0] LAST = `IHIU_FCNT_LAST;

  reg  [`IHIU_FCNT_W-1:0] cnt_ff;
  wire [`IHIU_FCNT_W-1:0] nxt_cnt;

  assign tick_o  = (cnt_ff == LAST);
  assign nxt_cnt = tick_o ? `IHIU_FCNT_ZERO : cnt_ff + `IHIU_FCNT_ONE;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= `IHIU_FCNT_ZERO;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// [ihiu_irq_unit.v]
// Operation
// RQ1 - At most one interrupt per frame
// RQ2 - Cause read deasserts output, clears cause
// RQ3 - Events during cause read held, applied after
// RQ4 - Reset clears all pending interrupt conditions
// RQ5 - Bits 0, 1, 4 flag buffer readiness
// RQ6 - Host loads transmit buffer within 375 us
// RQ7 - Host reads receive buffer within 425 us
// RQ8 - Host services B buffers within 122.4 us
// RQ9 - One shared cause bit for B channels
// RQ10 - Bits 2,3,5,6,7 summarise enabled status groups
// RQ11 - Every source disableable; bit 7 globally maskable
// RQ12 - Only enabled sources reach cause and output
// RQ13 - Global setup bit 2 forces output inactive
// RQ14 - Reads anytime; status frozen during status read
// RQ15 - Bits 0, 1 threshold, mask1 bits 0, 1
// RQ16 - Bit 2 collects three status-1 sources
// RQ17 - Bit 3 collects errors and packet lost
// RQ18 - Bit 4 enabled by mux control 4 bit 3
// RQ19 - Bit 5 collects four line status changes
// RQ20 - Bit 6 collects status-2 sources
// RQ21 - Bit 7 collects multiframe and port status
// RQ22 - Eight-bit data, three address, strobe decode
// RQ23 - Output low while enabled cause pending
// RQ24 - Causes sampled per frame, issued at boundary
`timescale 1ns/1ps
`include "ihiu_map.vh"

module ihiu_irq_unit (
  // System
  input  wire       clk_i,
  input  wire       rst_i,
  // Host port
  input  wire       cs_n_i,
  input  wire       rd_n_i,
  input  wire       wr_n_i,
  input  wire [2:0] addr_i,
  input  wire [7:0] data_i,
  output wire [7:0] data_o,
  output wire       data_oe_o,
  output wire       int_n_o,
  // Status freeze toward status register owners
  output wire       status_freeze_o,
  // Buffer ready sources
  input  wire       dtx_thresh_i,
  input  wire       drx_thresh_i,
  input  wire       bchan_ready_i,
  // Status and error sources
  input  wire [7:0] dlink_status_reg1_i,
  input  wire [7:0] dlink_status_reg2_i,
  input  wire [7:0] dlink_error_reg_i,
  input  wire [7:0] line_status_reg_i,
  input  wire [7:0] multiframe_status_i,
  input  wire [7:0] port_status_i,
  // Enables
  input  wire [7:0] dlink_mask_reg1_i,
  input  wire [7:0] dlink_error_mask_reg_i,
  input  wire [7:0] dlink_mask_reg3_i,
  input  wire [7:0] line_mode_reg2_i,
  input  wire [7:0] bchan_mux_ctrl4_i,
  input  wire [7:0] multiframe_ctrl_i,
  input  wire [7:0] port_irq_enable_i,
  input  wire [7:0] ext_feature_ctrl_i,
  input  wire       int_disable_i
);

  // Host access decode
  wire       rd_cyc;
  wire       cause_rd;
  wire       stat_rd;
  wire       cause_rd_end;

  // Source summary
  wire [7:0] cause_now;
  wire       grp_dstat1;
  wire       grp_derr;
  wire       grp_line;
  wire       grp_dstat2;
  wire       grp_port;
  wire [3:0] line_src;
  wire [3:0] line_en;
  wire [3:0] s2_src;
  wire [3:0] s2_en;
  wire [3:0] line_hit;
  wire [3:0] s2_hit;
  wire [7:0] err_hit;
  wire [2:0] mf_hit;
  wire [6:0] port_hit;
  wire       addr_dstat1;
  wire       addr_derr;
  wire       addr_dstat2;
  wire       int_pin_on;
  genvar     gi;

  // State
  reg  [7:0] pend_ff;
  reg  [7:0] cause_ff;
  reg        int_act_ff;
  reg        int_n_ff;
  reg        cause_rd_ff;
  reg        apply_due_ff;
  reg  [7:0] nxt_pend;
  reg  [7:0] nxt_cause;
  reg        nxt_int_act;
  reg        nxt_apply_due;
  wire       tick;
  wire       apply;

  ihiu_frame_timer u_frame (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // Direct register decode, strobes active low
  assign rd_cyc   = ~cs_n_i & ~rd_n_i & wr_n_i; // RQ22
  assign cause_rd = rd_cyc & (addr_i == `IHIU_ADDR_CAUSE); // RQ22
  assign addr_dstat1 = (addr_i == `IHIU_ADDR_DSTAT1);
  assign addr_derr   = (addr_i == `IHIU_ADDR_DERR);
  assign addr_dstat2 = (addr_i == `IHIU_ADDR_DSTAT2);
  assign stat_rd     = rd_cyc & (addr_dstat1 | addr_derr | addr_dstat2); // RQ14

  // Owners of the status registers hold their contents while this is high
  assign status_freeze_o = stat_rd; // RQ14

  // End of a cause read: strobe released after being seen low
  assign cause_rd_end = cause_rd_ff & ~cause_rd; // RQ2

  // Buffer readiness bits
  assign cause_now[`IHIU_CB_DTX] =
    dtx_thresh_i & dlink_mask_reg1_i[`IHIU_M1_TX]; // RQ5 RQ15
  assign cause_now[`IHIU_CB_DRX] =
    drx_thresh_i & dlink_mask_reg1_i[`IHIU_M1_RX]; // RQ5 RQ15
  assign cause_now[`IHIU_CB_BCHAN] =
    bchan_ready_i & bchan_mux_ctrl4_i[`IHIU_MUX4_BCHAN]; // RQ5 RQ9 RQ18

  // D-link status 1 group
  assign grp_dstat1 =
    (dlink_status_reg1_i[`IHIU_S1_ADDR] & dlink_mask_reg3_i[`IHIU_M3_ADDR]) |
    (dlink_status_reg1_i[`IHIU_S1_EOF] & dlink_mask_reg1_i[`IHIU_M1_EOF]) |
    (dlink_status_reg1_i[`IHIU_S1_FLAGTX] &
     dlink_mask_reg3_i[`IHIU_M3_FLAGTX]); // RQ16
  assign cause_now[`IHIU_CB_DSTAT1] = grp_dstat1; // RQ10

  // Error group: each error bit has its own enable of the same position
  generate
    for (gi = 0; gi < `IHIU_ERR_N; gi = gi + 1) begin : g_err
      assign err_hit[gi] = dlink_error_reg_i[gi] & dlink_error_mask_reg_i[gi]; // RQ17
    end
  endgenerate
  assign grp_derr =
    (|err_hit) |
    (dlink_status_reg2_i[`IHIU_S2_LOST] &
     dlink_mask_reg3_i[`IHIU_M3_LOST]); // RQ17
  assign cause_now[`IHIU_CB_DERR] = grp_derr; // RQ10

  // Line state change group
  assign line_src = {line_status_reg_i[`IHIU_LS_HOOK],
                     line_status_reg_i[`IHIU_LS_F8],
                     line_status_reg_i[`IHIU_LS_F7],
                     line_status_reg_i[`IHIU_LS_F3]};
  assign line_en  = {line_mode_reg2_i[`IHIU_LM_HOOK],
                     line_mode_reg2_i[`IHIU_LM_F8],
                     line_mode_reg2_i[`IHIU_LM_F7],
                     line_mode_reg2_i[`IHIU_LM_F3]};
  generate
    for (gi = 0; gi < `IHIU_LINE_N; gi = gi + 1) begin : g_line
      assign line_hit[gi] = line_src[gi] & line_en[gi]; // RQ19
    end
  endgenerate
  assign grp_line = |line_hit; // RQ19
  assign cause_now[`IHIU_CB_LINE] = grp_line; // RQ10

  // D-link status 2 group: four sources against four mask 3 enables, plus the second bit against ext feature bit 1
  assign s2_src = {dlink_status_reg2_i[`IHIU_S2_SPACETX],
                   dlink_status_reg2_i[`IHIU_S2_LASTTX],
                   dlink_status_reg2_i[`IHIU_S2_BYTERX],
                   dlink_status_reg2_i[`IHIU_S2_LASTRX]};
  assign s2_en  = {dlink_mask_reg3_i[`IHIU_M3_SPACETX],
                   dlink_mask_reg3_i[`IHIU_M3_LASTTX],
                   dlink_mask_reg3_i[`IHIU_M3_BYTERX],
                   dlink_mask_reg3_i[`IHIU_M3_LASTRX]};
  generate
    for (gi = 0; gi < `IHIU_S2_N; gi = gi + 1) begin : g_s2
      assign s2_hit[gi] = s2_src[gi] & s2_en[gi]; // RQ20
    end
  endgenerate
  assign grp_dstat2 =
    (|s2_hit) |
    (dlink_status_reg2_i[`IHIU_S2_SECOND] &
     ext_feature_ctrl_i[`IHIU_EF_SECOND]); // RQ20
  assign cause_now[`IHIU_CB_DSTAT2] = grp_dstat2; // RQ10

  // Multiframe and serial port group, with whole-group gate
  generate
    for (gi = 0; gi < `IHIU_MF_N; gi = gi + 1) begin : g_mf
      assign mf_hit[gi] = multiframe_status_i[`IHIU_MFS_LO + gi] &
                          multiframe_ctrl_i[`IHIU_MFC_LO + gi]; // RQ21
    end
    for (gi = 0; gi < `IHIU_PS_N; gi = gi + 1) begin : g_port
      assign port_hit[gi] = port_status_i[gi] & port_irq_enable_i[gi]; // RQ21 RQ11
    end
  endgenerate
  assign grp_port = ((|mf_hit) | (|port_hit)) &
                    port_irq_enable_i[`IHIU_PIE_GLOBAL]; // RQ21 RQ11
  assign cause_now[`IHIU_CB_PORT] = grp_port; // RQ10 RQ12

  // Pending causes move into the cause register once per frame, or on
  // the first cycle after a cause read that straddled the boundary.
  assign apply = (tick | apply_due_ff) & ~cause_rd; // RQ24 RQ3

  // Cause bits: a read end clears, an apply in the same cycle sets again
  always @* begin
    nxt_pend  = pend_ff | cause_now; // RQ12
    nxt_cause = cause_ff;
    if (cause_rd_end) begin
      nxt_cause = `IHIU_CAUSE_RST; // RQ2
    end
    if (apply) begin
      // Sources still active in this cycle stay pending: set wins
      nxt_pend  = cause_now;
      nxt_cause = nxt_cause | pend_ff; // RQ24
    end
  end

  // Interrupt request and the deferred apply
  always @* begin
    nxt_int_act   = int_act_ff;
    nxt_apply_due = apply_due_ff;
    if (tick & cause_rd) begin
      nxt_apply_due = 1'b1; // RQ3
    end
    if (cause_rd_end) begin
      nxt_int_act = 1'b0; // RQ2
    end
    if (apply) begin
      nxt_apply_due = 1'b0;
      if (|pend_ff) begin
        nxt_int_act = 1'b1; // RQ1 RQ24
      end
    end
  end

  // Pin level: active low, held high while the output is disabled
  assign int_pin_on = nxt_int_act & ~int_disable_i; // RQ13 RQ23

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_ff <= `IHIU_CAUSE_RST; // RQ4
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cause_ff <= `IHIU_CAUSE_RST; // RQ4
    end else begin
      cause_ff <= nxt_cause;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_act_ff <= 1'b0; // RQ4
    end else begin
      int_act_ff <= nxt_int_act;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_n_ff <= 1'b1; // RQ4
    end else begin
      int_n_ff <= ~int_pin_on; // RQ13 RQ23
    end
  end

  // Strobe history for the end of a cause read
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cause_rd_ff <= 1'b0;
    end else begin
      cause_rd_ff <= cause_rd;
    end
  end

  // Tick seen during a cause read, applied once the read ends
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      apply_due_ff <= 1'b0;
    end else begin
      apply_due_ff <= nxt_apply_due;
    end
  end

  // Cause register cannot change during a read, so it is driven directly
  assign data_o    = cause_ff;
  assign data_oe_o = cause_rd; // RQ14 RQ22
  assign int_n_o   = int_n_ff; // RQ23

endmodule

// [ihiu_irq_monitor.sv]
`timescale 1ns/1ps
module ihiu_irq_monitor (
  // System
  input wire       clk_i,
  input wire       rst_i,
  // Observed
  input wire       cs_n_i,
  input wire       rd_n_i,
  input wire       wr_n_i,
  input wire [2:0] addr_i,
  input wire [7:0] data_o,
  input wire       data_oe_o,
  input wire       int_n_o,
  input wire       status_freeze_o,
  input wire       int_disable_i
);
  reg [10:0] gap_ff;
  wire       rd_w  = !cs_n_i && !rd_n_i && wr_n_i;
  wire       sel_w = rd_w && addr_i == 3'h0;
  // Cycles since the cause register last gained bits
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      gap_ff <= 11'h7ff;
    else if (|(data_o & ~$past(data_o)))
      gap_ff <= 11'h000;
    else if (gap_ff != 11'h7ff)
      gap_ff <= gap_ff + 11'h001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd_end;
    sel_w ##1 !sel_w;
  endsequence
  AST_OE: assert property (data_oe_o == sel_w)
    else $error("oe mismatch");
  AST_FRZ: assert property (status_freeze_o == (rd_w && addr_i inside {3'h2, 3'h3, 3'h7}))
    else $error("freeze mismatch");
  AST_DIS: assert property (int_disable_i |=> int_n_o)
    else $error("pin not disabled");
  AST_CLR: assert property (s_rd_end |=> data_o == 8'h00 || !int_n_o || $past(int_disable_i))
    else $error("cause not cleared");
  AST_HOLD: assert property (sel_w ##1 sel_w |-> $stable(data_o))
    else $error("cause moved in read");
  AST_KEEP: assert property (!int_n_o && !int_disable_i && !sel_w && !$past(sel_w) |=> !int_n_o)
    else $error("int released early");
  AST_GAP: assert property (|(data_o & ~$past(data_o)) |-> gap_ff >= 11'd1200)
    else $error("two applies in a frame");
  AST_NEW: assert property (|(data_o & ~$past(data_o)) && !$past(int_disable_i) |-> !int_n_o)
    else $error("apply without int");
endmodule
bind ihiu_irq_unit ihiu_irq_monitor mon_u (.*);

// [ihiu_host_model.sv]
`timescale 1ns/1ps
module ihiu_host_model (
  // System
  input  wire       clk_i,
  // Bus from device
  input  wire [7:0] data_i,
  input  wire       oe_i,
  // Strobes
  output reg        cs_n_o = 1'b1,
  output reg        rd_n_o = 1'b1,
  output reg        wr_n_o = 1'b1,
  output reg  [2:0] addr_o = 3'h0,
  // Captured byte
  output reg        vld_o = 1'b0,
  output reg  [7:0] q_o = 8'h00
);
  reg  [7:0] last_ff = 8'h00;
  // Released bus shows the inverse of its last value
  wire [7:0] bus_w = oe_i ? data_i : ~last_ff;
  always @(posedge clk_i) last_ff <= bus_w;
  // One access: strobes driven for n cycles, bus byte and enable captured at the end
  task acc(input [2:0] a, input r, input w, input integer n);
    begin
      @(negedge clk_i);
      cs_n_o = 1'b0;
      rd_n_o = r;
      wr_n_o = w;
      addr_o = a;
      repeat (n) @(posedge clk_i);
      q_o = bus_w;
      vld_o = oe_i;
      @(negedge clk_i);
      {cs_n_o, rd_n_o, wr_n_o, vld_o} = 4'he;
    end
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
  reg         clk_i = 1'b0, rst_i = 1'b1, int_disable_i = 1'b0, noise = 1'b0;
  reg  [50:0] src = 51'h0;
  reg  [63:0] msk = 64'h0;
  reg  [7:0]  data_i = 8'h00;
  reg  [31:0] rs = 32'h0000315f;
  reg  [7:0]  exp_q[$];
  integer     failures = 0, comparisons = 0, i, e;
  int tbl [19] = '{0, 1011, 3162, 4032, 9172, 13223, 2274, 30355, 31385, 32365,
                   34375, 11186, 12196, 14206, 15216, 18576, 40417, 41427, 42437};
  wire [2:0]  addr_i;
  wire        cs_n_i, rd_n_i, wr_n_i, data_oe_o, int_n_o, status_freeze_o, vld;
  wire [7:0]  data_o, q;
  wire dtx_thresh_i = src[0], drx_thresh_i = src[1], bchan_ready_i = src[2];
  wire [7:0] dlink_status_reg1_i = src[10:3], dlink_status_reg2_i = src[18:11];
  wire [7:0] dlink_error_reg_i = src[26:19], line_status_reg_i = src[34:27];
  wire [7:0] multiframe_status_i = src[42:35], port_status_i = src[50:43];
  wire [7:0] dlink_mask_reg1_i = msk[7:0], dlink_error_mask_reg_i = msk[15:8];
  wire [7:0] dlink_mask_reg3_i = msk[23:16], bchan_mux_ctrl4_i = msk[31:24];
  wire [7:0] line_mode_reg2_i = msk[39:32], multiframe_ctrl_i = msk[47:40];
  wire [7:0] port_irq_enable_i = msk[55:48], ext_feature_ctrl_i = msk[63:56];
  ihiu_irq_unit dut_u (.*);
  ihiu_host_model host_u (.clk_i(clk_i), .data_i(data_o), .oe_i(data_oe_o), .cs_n_o(cs_n_i),
    .rd_n_o(rd_n_i), .wr_n_o(wr_n_i), .addr_o(addr_i), .vld_o(vld), .q_o(q));
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  always #50 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    rs = xs(rs);
    data_i = rs[7:0];
    if (noise)
      src = {rs[18:0], rs};
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  always @(posedge vld)
    chk(q, exp_q.size() ? exp_q.pop_front() : ~q);
  task wait_int(input integer n);
    integer j;
    begin
      for (j = 0; j < n && int_n_o !== 1'b0; j = j + 1)
        @(negedge clk_i);
      chk({7'h00, int_n_o}, 8'h00);
      if (int_n_o !== 1'b0)
        end_sim;
    end
  endtask
  task rd(input [7:0] x);
    begin
      exp_q.push_back(x);
      host_u.acc(3'h0, 1'b0, 1'b1, 3);
    end
  endtask
  task pulse(input integer s);
    begin
      src = 51'h1 << s;
      @(negedge clk_i);
      src = 51'h0;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    chk({7'h00, int_n_o}, 8'h01);
    host_u.acc(3'h0, 1'b0, 1'b0, 2);
    host_u.acc(3'h2, 1'b0, 1'b1, 3);
    rd(8'h00);
    $display("reset test done");
    msk = 64'h007f_0000_0000_0000;
    noise = 1'b1;
    repeat (1300) @(negedge clk_i);
    noise = 1'b0;
    chk({7'h00, int_n_o}, 8'h01);
    rd(8'h00);
    $display("mask test done");
    for (i = 0; i < 34; i = i + 1) begin
      e = i < 19 ? tbl[i] : i < 27 ? 19083 + (i - 19) * 1010 : 43487 + (i - 27) * 1010;
      msk = (64'h1 << ((e / 10) % 100)) | 64'h0080_0000_0000_0000;
      pulse(e / 1000);
      wait_int(2600);
      rd(8'h01 << (e % 10));
      repeat (2) @(negedge clk_i);
      chk({7'h00, int_n_o}, 8'h01);
    end
    $display("source test done");
    msk = 64'h3;
    pulse(0);
    wait_int(2600);
    rd(8'h01);
    pulse(1);
    repeat (1235) @(negedge clk_i);
    exp_q.push_back(8'h00);
    host_u.acc(3'h0, 1'b0, 1'b1, 20);
    wait_int(100);
    rd(8'h02);
    $display("deferral test done");
    int_disable_i = 1'b1;
    pulse(0);
    repeat (1300) @(negedge clk_i);
    chk({7'h00, int_n_o}, 8'h01);
    rd(8'h01);
    int_disable_i = 1'b0;
    $display("disable test done");
    end_sim;
  end
endmodule
